// >>> hw/fpc_fan_pwm_config.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_fan_pwm_config_regs.vh"

module fpc_fan_pwm_config #(
  parameter SLOW_DIV = `FPC_DIV_SLOW
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Sensor and fan
  input  wire [7:0]  temp_remote,
  input  wire        tach_in,
  input  wire        pwm_pin_in,
  output wire        pwm_pin_out,
  output reg         pwm_pin_oe,
  output wire        irq
);

  // ****************************************************
  // State
  // ****************************************************
  reg [5:0]  cfg_r;
  reg [2:0]  smooth_r;
  reg [7:0]  duty_prog_r;
  reg [7:0]  lut_r [0:23];
  reg [15:0] tach_cnt_r;
  reg [15:0] tach_read_r;
  reg [15:0] tach_limit_r;
  reg [1:0]  istat_r;
  reg [1:0]  imask_r;
  reg        tach_d_r;
  reg [12:0] div_r;
  reg [5:0]  pwm_cnt_r;
  reg        aw_full_r;
  reg [11:0] awaddr_r;
  reg        w_full_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;

  wire       prog_en = cfg_r[`FPC_CFG_PROG];
  wire       pol     = cfg_r[`FPC_CFG_POL];
  wire       csel    = cfg_r[`FPC_CFG_CSEL];

  // ****************************************************
  // Master clock divider
  // ****************************************************
  // fast clock forces mode 0
  wire [1:0] eff_mode = csel ? cfg_r[1:0] : 2'b00;

  localparam integer FAST_M1 = `FPC_DIV_FAST - 1;
  localparam integer SLOW_M1 = SLOW_DIV - 1;
  wire [12:0] div_lim = csel ? SLOW_M1[12:0] : FAST_M1[12:0];
  wire        mtick   = (div_r >= div_lim);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 13'h0000;
    end else if (mtick) begin
      div_r <= 13'h0000;
    end else begin
      div_r <= div_r + 13'h0001;
    end
  end

  // ****************************************************
  // Duty selection
  // ****************************************************
  reg [7:0] auto_duty;
  integer   i;
  integer   j;

  always @* begin
    auto_duty = 8'h00;
    for (i = 0; i < `FPC_LUT_ENTRIES; i = i + 1) begin
      if (temp_remote >= lut_r[2*i]) begin
        auto_duty = lut_r[2*i+1];
      end
    end
  end

  wire [7:0] duty = prog_en ? duty_prog_r : auto_duty;

  // ****************************************************
  // Speed sensing
  // ****************************************************
  wire        tach_rise = tach_in & ~tach_d_r;
  wire        cnt_top   = (tach_cnt_r == 16'hFFFF);
  reg         boost;
  reg         rd_upd;
  reg  [15:0] rd_new;

  always @* begin
    case (eff_mode)
      2'b10:   boost = (tach_cnt_r >= `FPC_BOOST_M2);
      2'b11:   boost = (tach_cnt_r >= `FPC_BOOST_M3);
      default: boost = 1'b0;
    endcase
    rd_upd = 1'b0;
    rd_new = tach_cnt_r;
    if (tach_rise) begin
      rd_upd = 1'b1;
    end else if (eff_mode != 2'b00 && cnt_top && mtick) begin
      rd_upd = 1'b1;
      rd_new = 16'hFFFF;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tach_d_r    <= 1'b0;
      tach_cnt_r  <= 16'h0000;
      tach_read_r <= 16'h0000;
    end else begin
      tach_d_r <= tach_in;
      if (rd_upd) begin
        tach_read_r <= rd_new;
      end
      if (tach_rise) begin
        // A tick on the edge belongs to the new period
        tach_cnt_r <= {15'h0000, mtick};
      end else if (mtick) begin
        if (!(eff_mode != 2'b00 && cnt_top)) begin
          tach_cnt_r <= tach_cnt_r + 16'h0001;
        end
      end
    end
  end

  // ****************************************************
  // PWM generator and output pin
  // ****************************************************
  wire fan_on = (duty > {2'b00, pwm_cnt_r}) | boost;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt_r  <= 6'h00;
      pwm_pin_oe <= 1'b1;
    end else begin
      if (mtick) begin
        pwm_cnt_r <= pwm_cnt_r + 6'h01;
      end
      pwm_pin_oe <= pol ? fan_on : ~fan_on;
    end
  end

  assign pwm_pin_out = 1'b0;

  // ****************************************************
  // Register bus
  // ****************************************************
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_arready = ~s_axi_rvalid;

  wire       wr_go  = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire [7:0] wr_idx = awaddr_r[9:2];
  wire       wr_lo  = (awaddr_r[11:10] == 2'b00) && (awaddr_r[1:0] == 2'b00);
  wire [7:0] wr_lut = wr_idx - `FPC_IDX_LUT_FIRST;
  wire       wr_in_lut = wr_idx >= `FPC_IDX_LUT_FIRST &&
                         wr_idx <= `FPC_IDX_LUT_LAST;
  reg        wr_ok;

  always @* begin
    case (wr_idx)
      `FPC_IDX_SMOOTH, `FPC_IDX_CONFIG, `FPC_IDX_DUTY,
      `FPC_IDX_LIMIT, `FPC_IDX_ISTAT, `FPC_IDX_IMASK: wr_ok = wr_lo;
      default: wr_ok = wr_lo & wr_in_lut;
    endcase
  end

  wire       wr_b0 = wr_go & wr_ok & wstrb_r[0];
  wire [1:0] clr   = (wr_b0 && wr_idx == `FPC_IDX_ISTAT) ?
                     wdata_r[1:0] : 2'b00;
  wire [1:0] ev;
  assign ev[`FPC_IRQ_TACH_DONE] = rd_upd;
  assign ev[`FPC_IRQ_TACH_ERR]  = rd_upd && (rd_new > tach_limit_r);

  assign irq = |(istat_r & imask_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r    <= 1'b0;
      w_full_r     <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FPC_RESP_OKAY;
      cfg_r        <= `FPC_CFG_RESET;
      smooth_r     <= 3'h0;
      duty_prog_r  <= 8'h00;
      tach_limit_r <= `FPC_LIMIT_RESET;
      istat_r      <= 2'b00;
      imask_r      <= 2'b00;
      for (j = 0; j < 24; j = j + 1) begin
        lut_r[j] <= 8'h00;
      end
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Set beats clear in the same cycle
      istat_r <= (istat_r & ~clr) | ev;
      if (wr_b0) begin
        if (wr_idx == `FPC_IDX_CONFIG) cfg_r <= wdata_r[5:0];
        if (wr_idx == `FPC_IDX_IMASK) imask_r <= wdata_r[1:0];
        if (wr_idx == `FPC_IDX_LIMIT) tach_limit_r[7:0] <= wdata_r[7:0];
        if (prog_en) begin
          if (wr_idx == `FPC_IDX_DUTY) duty_prog_r <= wdata_r[7:0];
          if (wr_idx == `FPC_IDX_SMOOTH) smooth_r <= wdata_r[2:0];
          if (wr_in_lut) lut_r[wr_lut[4:0]] <= wdata_r[7:0];
        end
      end
      if (wr_go && wr_ok && wstrb_r[1] && wr_idx == `FPC_IDX_LIMIT) begin
        tach_limit_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  // ****************************************************
  // Read path
  // ****************************************************
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire [7:0] rd_lut = rd_idx - `FPC_IDX_LUT_FIRST;
  wire       rd_lo  = (s_axi_araddr[11:10] == 2'b00) &&
                      (s_axi_araddr[1:0] == 2'b00);
  reg [31:0] rd_data;
  reg        rd_ok;

  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = rd_lo;
    case (rd_idx)
      `FPC_IDX_SMOOTH: rd_data = {29'h0000_0000, smooth_r};
      `FPC_IDX_CONFIG: rd_data = {26'h000_0000, cfg_r};
      `FPC_IDX_DUTY:   rd_data = {24'h00_0000, duty};
      `FPC_IDX_TACH:   rd_data = {16'h0000, tach_read_r};
      `FPC_IDX_LIMIT:  rd_data = {16'h0000, tach_limit_r};
      `FPC_IDX_ISTAT:  rd_data = {30'h0000_0000, istat_r};
      `FPC_IDX_IMASK:  rd_data = {30'h0000_0000, imask_r};
      default: begin
        if (rd_idx >= `FPC_IDX_LUT_FIRST && rd_idx <= `FPC_IDX_LUT_LAST) begin
          rd_data = {24'h00_0000, lut_r[rd_lut[4:0]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FPC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
      s_axi_rresp  <= rd_ok ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> hw/fpc_fan_pwm_config_regs.vh
// Notes on behaviour
// - Config bits 7:6 always read zero
// - Program enable low: duty, smoothing, table locked
// - Program enable low: duty follows temperature table
// - Program enable high: written duty drives output
// - Polarity picks which level means fan on
// - Clock select: 360 kHz or 1.4 kHz master
// - Speed mode 0: plain counting, no assist
// - Speed mode 1: all ones when slow, duty untouched
// - Speed mode 1: limit below all ones flags error
// - Speed mode 2: duty modified, all ones when slow
// - Speed mode 3: least duty disturbance, all ones
// - Fast master clock forces speed mode 0
`ifndef FPC_FAN_PWM_CONFIG_REGS_VH
`define FPC_FAN_PWM_CONFIG_REGS_VH

// Register indices, byte address is four times the index
`define FPC_IDX_SMOOTH    8'h45
`define FPC_IDX_CONFIG    8'h4A
`define FPC_IDX_DUTY      8'h4C
`define FPC_IDX_LUT_FIRST 8'h50
`define FPC_IDX_LUT_LAST  8'h67
`define FPC_IDX_TACH      8'h70
`define FPC_IDX_LIMIT     8'h72
`define FPC_IDX_ISTAT     8'h74
`define FPC_IDX_IMASK     8'h75

// Config fields
`define FPC_CFG_PROG      5
`define FPC_CFG_POL       4
`define FPC_CFG_CSEL      3
`define FPC_CFG_RESET     6'h20
`define FPC_LUT_ENTRIES   12

// Interrupt status bits
`define FPC_IRQ_TACH_ERR  0
`define FPC_IRQ_TACH_DONE 1

// Timing
`define FPC_CLK_HZ        10000000
`define FPC_MCLK_FAST_HZ  360000
`define FPC_MCLK_SLOW_HZ  1400
`define FPC_DIV_FAST      (`FPC_CLK_HZ / `FPC_MCLK_FAST_HZ)
`define FPC_DIV_SLOW      (`FPC_CLK_HZ / `FPC_MCLK_SLOW_HZ)
`define FPC_BOOST_M2      16'h0400
`define FPC_BOOST_M3      16'h4000
`define FPC_LIMIT_RESET   16'hFFFF

`define FPC_RESP_OKAY     2'b00
`define FPC_RESP_SLVERR   2'b10

`endif

// >>> dv/fpc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Fan pin and interrupt
  input wire logic        pwm_pin_out,
  input wire logic        pwm_pin_oe,
  input wire logic        irq
);
  logic [11:0] rd_addr_r;
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_CFG_TOP: assert property (
    s_axi_rvalid && rd_addr_r == 12'h128 |-> s_axi_rdata[31:6] == 0)
    else $error("config upper bits not zero");
  AST_RST_OUT: assert property ($rose(aresetn) |-> pwm_pin_oe && !irq)
    else $error("outputs wrong after reset");
  AST_WR_RSP: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  AST_RD_LAT: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  AST_SLVERR: assert property (
    s_axi_rvalid && s_axi_rresp != 0 |-> s_axi_rdata == 0)
    else $error("error read returned data");
  AST_OD: assert property (!pwm_pin_out)
    else $error("open drain pin driven high");
endmodule
bind fpc_fan_pwm_config fpc_checker i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pwm_pin_out, .pwm_pin_oe, .irq);
`default_nettype wire

// >>> dv/fpc_fan_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_fan_model (
  // Drive pin
  input  wire logic        aclk,
  input  wire logic        pwm_pin_out,
  input  wire logic        pwm_pin_oe,
  output wire logic        pin_level,
  // Tach, half period in clocks, zero means stalled
  input  wire logic [15:0] half_period,
  output var  logic        tach_out
);
  int cnt = 0;
  assign pin_level = pwm_pin_oe ? pwm_pin_out : 1'b1;
  initial tach_out = 1'b0;
  always @(posedge aclk) begin
    cnt <= (half_period == 0 || cnt + 1 >= half_period) ? 0 : cnt + 1;
    if (half_period == 0) tach_out <= 1'b0;
    else if (cnt + 1 >= half_period) tach_out <= !tach_out;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpc_fan_pwm_config_regs.vh"
module tb_top;
  localparam int SLOW = 4;
  localparam bit [7:0] CFG = `FPC_IDX_CONFIG, DUTY = `FPC_IDX_DUTY;
  localparam bit [7:0] TACH = `FPC_IDX_TACH, LIM = `FPC_IDX_LIMIT;
  localparam bit [7:0] IST = `FPC_IDX_ISTAT, IMK = `FPC_IDX_IMASK;
  logic        aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, oe, pout, irq;
  logic        tach, pin;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  temp = 0;
  logic [15:0] half = 270;
  int          fail_count = 0, checks_done = 0, cycles = 0, k;
  fpc_fan_pwm_config #(.SLOW_DIV(SLOW)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .temp_remote(temp),
    .tach_in(tach), .pwm_pin_in(pin), .pwm_pin_out(pout),
    .pwm_pin_oe(oe), .irq);
  fpc_fan_model i_fan (.aclk, .pwm_pin_out(pout), .pwm_pin_oe(oe),
    .pin_level(pin), .half_period(half), .tach_out(tach));
  // ****************
  // Bench tasks
  // ****************
  initial forever #50 aclk = !aclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk(bresp, `FPC_RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    @(posedge aclk);
    araddr <= {2'b00, i, 2'b00};
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    rsp = rresp;
    chk(rdata, e);
  endtask
  task automatic on_time(input int n);
    k = 0;
    repeat (n) begin
      @(posedge aclk);
      k += int'(!oe);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    cyc(2);
    aresetn <= 1;
    rd(CFG, 32'h0000_0020);
    chk(oe, 1);
    wr(CFG, 32'h0000_00F3);
    rd(CFG, 32'h0000_0033);
    rd(8'h7F, 0);
    chk(rsp, `FPC_RESP_SLVERR);
    $display("test config done");
    wr(CFG, 32'h0000_0020);
    wr(DUTY, 32'h0000_0040);
    cyc(3);
    chk(oe, 0);
    wr(CFG, 32'h0000_0030);
    cyc(3);
    chk(oe, 1);
    wr(DUTY, 0);
    cyc(3);
    chk(oe, 0);
    $display("test polarity done");
    wr(CFG, 32'h0000_0020);
    wr(DUTY, 32'h0000_0020);
    on_time(64 * `FPC_DIV_FAST);
    chk(k, 32 * `FPC_DIV_FAST);
    wr(CFG, 32'h0000_0028);
    cyc(64 * SLOW + 50);
    on_time(64 * SLOW);
    chk(k, 32 * SLOW);
    $display("test clock done");
    wr(CFG, 32'h0000_0020);
    for (int i = 0; i < 12; i++) begin
      wr(8'h50 + 8'(2 * i), 16 * i);
      wr(8'h51 + 8'(2 * i), 4 * i);
    end
    temp <= 8'h35;
    wr(CFG, 0);
    rd(DUTY, 12);
    wr(DUTY, 32'h0000_003F);
    wr(8'h57, 0);
    rd(DUTY, 12);
    rd(8'h57, 12);
    temp <= 8'hFF;
    cyc(3);
    rd(DUTY, 44);
    $display("test table done");
    wr(CFG, 32'h0000_0020);
    cyc(1200);
    rd(TACH, 2 * 270 / `FPC_DIV_FAST);
    half <= 40;
    wr(CFG, 32'h0000_0029);
    cyc(400);
    rd(TACH, 2 * 40 / SLOW);
    wr(LIM, 10);
    wr(IMK, 1);
    cyc(200);
    chk(irq, 1);
    rd(IST, 3);
    wr(IMK, 0);
    cyc(2);
    chk(irq, 0);
    wr(LIM, 32'h0000_FFFF);
    wr(IST, 3);
    wr(IMK, 1);
    cyc(200);
    chk(irq, 0);
    $display("test tach done");
    wr(DUTY, 0);
    half <= 0;
    wr(CFG, 32'h0000_002A);
    cyc(SLOW * 32'h0000_0400 + 200);
    chk(oe, 0);
    wr(CFG, 32'h0000_002B);
    cyc(5);
    chk(oe, 1);
    wr(CFG, 32'h0000_0029);
    cyc(5);
    chk(oe, 1);
    wr(CFG, 32'h0000_0022);
    cyc(5);
    chk(oe, 1);
    $display("test speed mode done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
